/* pwd_pkg.sv */
// constants, field layouts and types of the two-channel pwm register block
package pwd_pkg;

    // register index within a channel; byte address = 4 * (8 * channel + index)
    localparam logic [2:0] IDX_CTRL  = 3'h0;
    localparam logic [2:0] IDX_PER_L = 3'h1;
    localparam logic [2:0] IDX_PER_H = 3'h2;
    localparam logic [2:0] IDX_DUT_L = 3'h3;
    localparam logic [2:0] IDX_DUT_H = 3'h4;
    localparam logic [2:0] IDX_DT_L  = 3'h5;
    localparam logic [2:0] IDX_DT_H  = 3'h6;
    // shared configuration register index (mode and auto-reload bits)
    localparam logic [4:0] IDX_CFG   = 5'h10;

    // configuration field positions and reset value (auto-reload on)
    localparam int         CFG_IND_BIT    = 0;
    localparam int         CFG_RELOAD_BIT = 2;
    localparam logic [7:0] CFG_RESET      = 8'h0c;
    localparam logic [7:0] REG_RESET      = 8'h00;

    // prescaler terminal counts for divide by 1, 8, 32, 128
    localparam logic [6:0] DIV_TC1   = 7'h00;
    localparam logic [6:0] DIV_TC8   = 7'h07;
    localparam logic [6:0] DIV_TC32  = 7'h1f;
    localparam logic [6:0] DIV_TC128 = 7'h7f;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       irq_en;     // interrupt enable
        logic       ovf_flag;   // period overflow flag
        logic       flt_stat;   // fault shutdown status
        logic       flt_pol;    // fault input level that shuts down
        logic [1:0] out_pol;    // [1] primary low active, [0] secondary low active
        logic [1:0] clk_div;    // prescaler select
    } pwd_ctrl_s;

endpackage

/* pwd_top.sv */
// two-channel 12-bit pwm with dead time, fault shutdown and avalon-mm registers
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module pwd_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [6:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ch0_fault_input,
    input  wire logic        ch1_fault_input,
    output logic             ch0_primary_out,
    output logic             ch0_secondary_out,
    output logic             ch1_primary_out,
    output logic             ch1_secondary_out,
    output logic             ch0_irq,
    output logic             ch1_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bus slave

    // word index of a channel register
    function automatic logic [4:0] reg_idx(input logic ch, input logic [2:0] k);
        return {1'b0, ch, k};
    endfunction

    wire        bus_req = avs_read | avs_write;        // request present
    wire        bus_acc = bus_req & ~avs_waitrequest;  // edge where access completes
    wire [4:0]  bus_idx = avs_address[6:2];            // word index
    wire        bus_wr  = avs_write & bus_acc & avs_byteenable[0]; // data lives in lane 0
    wire [7:0]  bus_wd  = avs_writedata[7:0];

    // register storage, one element per channel, except the shared cfg
    pwd_pkg::pwd_ctrl_s ctrl [2];      // control register
    logic [7:0]  per_lo [2];           // period low byte
    logic [3:0]  per_hi [2];           // period high nibble
    logic [7:0]  dut_lo [2];           // duty low byte
    logic [3:0]  dut_hi [2];           // duty high nibble
    logic [7:0]  dt_lo  [2];           // dead time low byte
    logic [3:0]  dt_hi  [2];           // dead time high nibble
    logic [7:0]  cfg;                  // mode and auto-reload bits

    // channel state
    logic [6:0]  psc     [2];          // prescaler count
    logic [11:0] cnt     [2];          // period counter
    logic [11:0] buf_per [2];          // staged values, loaded by low writes
    logic [11:0] buf_dut [2];
    logic [11:0] buf_dt  [2];
    logic [11:0] act_per [2];          // values in use this period
    logic [11:0] act_dut [2];
    logic [11:0] act_dt  [2];
    logic [1:0]  flt_s1;               // fault synchroniser first stage
    logic [1:0]  flt_s2;               // fault synchroniser second stage
    logic [1:0]  prim_q;               // output flops
    logic [1:0]  sec_q;
    logic [1:0]  irq_q;
    logic [1:0]  tick;                 // prescaled clock tick
    logic [1:0]  ovf;                  // period counter overflow
    wire  [1:0]  flt_in = {ch1_fault_input, ch0_fault_input};

    // read mux, reserved high bits and unmapped words read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (bus_idx == pwd_pkg::IDX_CFG) begin
            rd_mux = cfg;
        end else if (!bus_idx[4]) begin
            case (bus_idx[2:0])
                pwd_pkg::IDX_CTRL:  rd_mux = ctrl[bus_idx[3]];
                pwd_pkg::IDX_PER_L: rd_mux = per_lo[bus_idx[3]];
                pwd_pkg::IDX_PER_H: rd_mux = {4'h0, per_hi[bus_idx[3]]};
                pwd_pkg::IDX_DUT_L: rd_mux = dut_lo[bus_idx[3]];
                pwd_pkg::IDX_DUT_H: rd_mux = {4'h0, dut_hi[bus_idx[3]]};
                pwd_pkg::IDX_DT_L:  rd_mux = dt_lo[bus_idx[3]];
                pwd_pkg::IDX_DT_H:  rd_mux = {4'h0, dt_hi[bus_idx[3]]};
                default:            rd_mux = 8'h00;
            endcase
        end
    end

    // one wait cycle per access: waitrequest drops for exactly one edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // shared configuration register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg <= pwd_pkg::CFG_RESET;
        end else if (bus_wr && bus_idx == pwd_pkg::IDX_CFG) begin
            cfg <= {4'h0, bus_wd[3:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channels

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            // register write strobes
            wire we_ctrl  = bus_wr && bus_idx == reg_idx(g[0], pwd_pkg::IDX_CTRL);
            wire we_per_l = bus_wr && bus_idx == reg_idx(g[0], pwd_pkg::IDX_PER_L);
            wire we_per_h = bus_wr && bus_idx == reg_idx(g[0], pwd_pkg::IDX_PER_H);
            wire we_dut_l = bus_wr && bus_idx == reg_idx(g[0], pwd_pkg::IDX_DUT_L);
            wire we_dut_h = bus_wr && bus_idx == reg_idx(g[0], pwd_pkg::IDX_DUT_H);
            wire we_dt_l  = bus_wr && bus_idx == reg_idx(g[0], pwd_pkg::IDX_DT_L);
            wire we_dt_h  = bus_wr && bus_idx == reg_idx(g[0], pwd_pkg::IDX_DT_H);
            wire indep    = cfg[pwd_pkg::CFG_IND_BIT + g];
            wire reload   = cfg[pwd_pkg::CFG_RELOAD_BIT + g];

            // prescaler terminal count from the clock select field
            logic [6:0] tc;
            always_comb begin
                case (ctrl[g].clk_div)
                    2'h0:    tc = pwd_pkg::DIV_TC1;
                    2'h1:    tc = pwd_pkg::DIV_TC8;
                    2'h2:    tc = pwd_pkg::DIV_TC32;
                    default: tc = pwd_pkg::DIV_TC128;
                endcase
            end
            assign tick[g] = (psc[g] >= tc);

            // wrap point: a zero period wraps on every tick
            wire [11:0] wrap_pt = (act_per[g] == 12'h000) ? 12'h000 : act_per[g] - 12'h001;
            assign ovf[g] = tick[g] & (cnt[g] >= wrap_pt);

            // interval decode on 13 bits so sums cannot overflow
            wire [12:0] c13      = {1'b0, cnt[g]};
            wire [12:0] sec_on   = {1'b0, act_dut[g]} + {1'b0, act_dt[g]};
            wire [12:0] sec_off  = c13 + {1'b0, act_dt[g]};
            wire        prim_act = cnt[g] < act_dut[g];
            wire        comp_act = (c13 >= sec_on) && (sec_off < {1'b0, act_per[g]});
            wire        sec_act  = indep ? (cnt[g] < act_dt[g]) : comp_act;
            wire        flt_hit  = (flt_s2[g] == ctrl[g].flt_pol);

            // prescaler and period counter
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    psc[g] <= 7'h00;
                    cnt[g] <= 12'h000;
                end else begin
                    psc[g] <= tick[g] ? 7'h00 : psc[g] + 7'h01;
                    if (tick[g]) begin
                        cnt[g] <= ovf[g] ? 12'h000 : cnt[g] + 12'h001;
                    end
                end
            end

            // setting registers; a low write stages the full 12-bit value
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    per_lo[g]  <= pwd_pkg::REG_RESET;
                    per_hi[g]  <= 4'h0;
                    dut_lo[g]  <= pwd_pkg::REG_RESET;
                    dut_hi[g]  <= 4'h0;
                    dt_lo[g]   <= pwd_pkg::REG_RESET;
                    dt_hi[g]   <= 4'h0;
                    buf_per[g] <= 12'h000;
                    buf_dut[g] <= 12'h000;
                    buf_dt[g]  <= 12'h000;
                end else begin
                    if (we_per_h) per_hi[g] <= bus_wd[3:0];
                    if (we_dut_h) dut_hi[g] <= bus_wd[3:0];
                    if (we_dt_h)  dt_hi[g]  <= bus_wd[3:0];
                    if (we_per_l) begin
                        per_lo[g]  <= bus_wd;
                        buf_per[g] <= {per_hi[g], bus_wd};
                    end
                    if (we_dut_l) begin
                        dut_lo[g]  <= bus_wd;
                        buf_dut[g] <= {dut_hi[g], bus_wd};
                    end
                    if (we_dt_l) begin
                        dt_lo[g]  <= bus_wd;
                        buf_dt[g] <= {dt_hi[g], bus_wd};
                    end
                end
            end

            // values in use change only at overflow while auto-reload is on
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    act_per[g] <= 12'h000;
                    act_dut[g] <= 12'h000;
                    act_dt[g]  <= 12'h000;
                end else if (ovf[g] && reload) begin
                    act_per[g] <= buf_per[g];
                    act_dut[g] <= buf_dut[g];
                    act_dt[g]  <= buf_dt[g];
                end
            end

            // control register: hardware set wins over a software clear
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    ctrl[g] <= pwd_pkg::REG_RESET;
                end else begin
                    if (we_ctrl) begin
                        ctrl[g].irq_en  <= bus_wd[7];
                        ctrl[g].flt_pol <= bus_wd[4];
                        ctrl[g].out_pol <= bus_wd[3:2];
                        ctrl[g].clk_div <= bus_wd[1:0];
                    end
                    // writing 0 clears, writing 1 leaves the flag alone
                    ctrl[g].ovf_flag <= ovf[g] | (ctrl[g].ovf_flag & ~(we_ctrl & ~bus_wd[6]));
                    ctrl[g].flt_stat <= flt_hit | (ctrl[g].flt_stat & ~(we_ctrl & ~bus_wd[5]));
                end
            end

            // fault input synchroniser and registered outputs
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    flt_s1[g] <= 1'b1;  // idle at the level that does not trip the reset polarity,
                    flt_s2[g] <= 1'b1;  // so no false fault status right after reset
                    prim_q[g] <= 1'b0;
                    sec_q[g]  <= 1'b0;
                    irq_q[g]  <= 1'b0;
                end else begin
                    flt_s1[g] <= flt_in[g];
                    flt_s2[g] <= flt_s1[g];
                    prim_q[g] <= (prim_act & ~ctrl[g].flt_stat) ^ ctrl[g].out_pol[1];
                    sec_q[g]  <= (sec_act & ~ctrl[g].flt_stat) ^ ctrl[g].out_pol[0];
                    irq_q[g]  <= ctrl[g].irq_en & ctrl[g].ovf_flag;
                end
            end
        end
    endgenerate

    // pins and interrupt requests
    assign ch0_primary_out   = prim_q[0];
    assign ch1_primary_out   = prim_q[1];
    assign ch0_secondary_out = sec_q[0];
    assign ch1_secondary_out = sec_q[1];
    assign ch0_irq           = irq_q[0];
    assign ch1_irq           = irq_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    wire rd_hi0 = avs_read & avs_waitrequest && bus_idx == reg_idx(1'b0, pwd_pkg::IDX_DUT_H);

    property p_hi_reads_zero;
        @(posedge clk) disable iff (!nrst) rd_hi0 |=> (avs_readdata[31:4] == 28'h0);
    endproperty
    a_hi_reads_zero: assert property (p_hi_reads_zero) else $error("high register upper bits not zero");

    property p_duty_held;
        @(posedge clk) disable iff (!nrst) !ovf[0] |=> (act_dut[0] == $past(act_dut[0]));
    endproperty
    a_duty_held: assert property (p_duty_held) else $error("duty changed inside a period");

    property p_per_hi_alone;
        @(posedge clk) disable iff (!nrst)
            (bus_wr && bus_idx == reg_idx(1'b0, pwd_pkg::IDX_PER_H)) |=> (buf_per[0] == $past(buf_per[0]));
    endproperty
    a_per_hi_alone: assert property (p_per_hi_alone) else $error("period high write changed period");

    property p_ovf_flag;
        @(posedge clk) disable iff (!nrst) ovf[0] |=> ctrl[0].ovf_flag;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_fault_set;
        @(posedge clk) disable iff (!nrst) (flt_s2[1] == ctrl[1].flt_pol) |=> ctrl[1].flt_stat;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault status not set");

    property p_fault_off;
        @(posedge clk) disable iff (!nrst)
            ctrl[1].flt_stat |=> (prim_q[1] == $past(ctrl[1].out_pol[1])) && (sec_q[1] == $past(ctrl[1].out_pol[0]));
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("outputs active during fault");

    property p_div8;
        @(posedge clk) disable iff (!nrst)
            (tick[0] && ctrl[0].clk_div == 2'h1 && !(bus_wr && bus_idx == 5'h00)) |=> !tick[0] [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 tick spacing wrong");

    property p_irq_gate;
        @(posedge clk) disable iff (!nrst) ch1_irq |-> $past(ctrl[1].irq_en) && $past(ctrl[1].ovf_flag);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable and flag");

    property p_frozen;
        @(posedge clk) disable iff (!nrst) !cfg[pwd_pkg::CFG_RELOAD_BIT]
            |=> (act_per[0] == $past(act_per[0])) && (act_dut[0] == $past(act_dut[0]));
    endproperty
    a_frozen: assert property (p_frozen) else $error("values in use changed with reload off");

    c_overflow: cover property (@(posedge clk) disable iff (!nrst) ovf[0] && act_per[0] > 12'h003);
    c_fault:    cover property (@(posedge clk) disable iff (!nrst) ctrl[1].flt_stat);
    c_indep:    cover property (@(posedge clk) disable iff (!nrst) cfg[0] && act_dt[0] != 12'h000 && sec_q[0]);
    c_read:     cover property (@(posedge clk) disable iff (!nrst) avs_read && !avs_waitrequest);

endmodule

/* pwd_switch_stage.sv */
// power switch stage model: counts gate pin high time, drives the fault pins
`timescale 1ns/1ps
module pwd_switch_stage (
    input  wire logic             clk,
    input  wire logic             ch0_primary_out,
    input  wire logic             ch0_secondary_out,
    input  wire logic             ch1_primary_out,
    input  wire logic             ch1_secondary_out,
    input  wire logic [1:0]       fault_level,
    input  wire logic             count_clear,
    output logic                  ch0_fault_input,
    output logic                  ch1_fault_input,
    output logic      [3:0][15:0] high_count
);
    logic [3:0] gate; // gate pins gathered for one counting loop
    assign gate = {ch1_secondary_out, ch1_primary_out, ch0_secondary_out, ch0_primary_out};
    // the stage fault comparators always drive a level, never float
    assign ch0_fault_input = fault_level[0];
    assign ch1_fault_input = fault_level[1];
    ////////////////////////////////////////////////////////////////
    // count clocks each gate pin spends high, cleared on request
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            high_count[i] <= count_clear ? 16'h0000 : high_count[i] + 16'(gate[i]);
        end
    end
endmodule

/* testbench.sv */
// self-checking bench of the two-channel pwm register block
`timescale 1ns/1ps
module testbench;
    logic clk, nrst, avs_read, avs_write, count_clear;
    logic [6:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, ch0_irq, ch1_irq, ch0_flt, ch1_flt;
    logic ch0_p, ch0_s, ch1_p, ch1_s;
    logic [1:0] fault_level;       // commanded fault pin levels
    logic [3:0][15:0] high_count;  // gate high time from the stage
    logic [3:0][15:0] cnt;         // captured counts
    logic [31:0] seed;             // random state
    logic [7:0] junk;              // unused read data
    int err_count, compares, n, c, d1, t1;
    logic [2:0] k;
    pwd_top pwd_top_inst (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ch0_fault_input(ch0_flt),
        .ch1_fault_input(ch1_flt), .ch0_primary_out(ch0_p), .ch0_secondary_out(ch0_s),
        .ch1_primary_out(ch1_p), .ch1_secondary_out(ch1_s), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq));
    pwd_switch_stage pwd_switch_stage_inst (.clk(clk), .ch0_primary_out(ch0_p), .ch0_secondary_out(ch0_s),
        .ch1_primary_out(ch1_p), .ch1_secondary_out(ch1_s), .fault_level(fault_level),
        .count_clear(count_clear), .ch0_fault_input(ch0_flt), .ch1_fault_input(ch1_flt),
        .high_count(high_count));
    ////////////////////////////////////////////////////////////////
    // helpers: random source, index map, expected counts
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [4:0] ix(input int ch, input logic [2:0] idx);
        return 5'(8 * ch) | {2'b00, idx};
    endfunction
    function automatic int div_of(input int code);
        return 1 << (code == 0 ? 0 : 2 * code + 1);
    endfunction
    function automatic logic [15:0] exp_high(input int act, input int total, input logic inv);
        return 16'(inv ? total - act : act);
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // avalon master: hold request until waitrequest is sampled low
    task automatic bus_cycle(input logic wr, input logic [4:0] idx, input logic [7:0] val,
                             input logic [3:0] be, output logic [7:0] rd);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, val};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // no cycle count assumed: a slave that never answers is caught by the watchdog
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] idx, input logic [7:0] val);
        bus_cycle(1'b1, idx, val, 4'hf, junk);
    endtask
    task automatic rd_check(input logic [4:0] idx, input logic [7:0] mask, input logic [7:0] exp, input string msg);
        logic [7:0] got;
        bus_cycle(1'b0, idx, 8'h00, 4'hf, got);
        check(16'(got & mask), 16'(exp), msg);
    endtask
    // program one channel, high halves always before low halves
    task automatic set_ch(input int ch, input logic [7:0] ctrl, input logic [11:0] per, duty, dt);
        wr(ix(ch, pwd_pkg::IDX_CTRL), ctrl);
        wr(ix(ch, pwd_pkg::IDX_PER_H), {4'h0, per[11:8]});
        wr(ix(ch, pwd_pkg::IDX_PER_L), per[7:0]);
        wr(ix(ch, pwd_pkg::IDX_DUT_H), {4'h0, duty[11:8]});
        wr(ix(ch, pwd_pkg::IDX_DUT_L), duty[7:0]);
        wr(ix(ch, pwd_pkg::IDX_DT_H), {4'h0, dt[11:8]});
        wr(ix(ch, pwd_pkg::IDX_DT_L), dt[7:0]);
    endtask
    // settle, then count gate high clocks over a whole number of periods
    task automatic settle_measure(input int cycles);
        repeat (cycles) @(posedge clk);
        count_clear <= 1'b1;
        @(posedge clk);
        count_clear <= 1'b0;
        repeat (cycles) @(posedge clk);
        @(negedge clk);
        cnt = high_count;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end
    // main sequence
    initial begin
        {nrst, avs_read, avs_write, count_clear, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        fault_level = 2'b11;
        seed = 32'h4ac50bc0;
        err_count = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // reset values, unmapped place, disabled byte lane
        rd_check(pwd_pkg::IDX_CFG, 8'hff, pwd_pkg::CFG_RESET, "config reset");
        for (int i = 0; i < 14; i++) begin
            rd_check(ix(i / 7, 3'(i % 7)), (i % 7 == 0) ? 8'hbf : 8'hff, 8'h00, "reset value");
        end
        wr(5'h07, 8'h5a);
        rd_check(5'h07, 8'hff, 8'h00, "unmapped place");
        bus_cycle(1'b1, ix(0, pwd_pkg::IDX_DUT_L), 8'h33, 4'h0, junk);
        rd_check(ix(0, pwd_pkg::IDX_DUT_L), 8'hff, 8'h00, "byte lane off");
        $display("test reset done");
        // random write and read back, high halves keep four bits
        for (int i = 0; i < 24; i++) begin
            seed = lfsr_next(seed);
            c = int'(seed[8]);
            k = 3'(1 + seed[11:9] % 6);
            wr(ix(c, k), seed[7:0]);
            rd_check(ix(c, k), 8'hff, k[0] ? seed[7:0] : (seed[7:0] & 8'h0f), "read back");
        end
        // short periods again, so later settings land within a few clocks
        for (int ch = 0; ch < 2; ch++) begin
            wr(ix(ch, pwd_pkg::IDX_PER_H), 8'h00);
            wr(ix(ch, pwd_pkg::IDX_PER_L), 8'h0c);
        end
        repeat (4200) @(posedge clk);
        $display("test registers done");
        // prescaler sweep on a complementary pair
        for (int dv = 0; dv < 4; dv++) begin
            set_ch(0, 8'(dv), 12'h00c, 12'h005, 12'h002);
            settle_measure(24 * div_of(dv));
            check(cnt[0], 16'(10 * div_of(dv)), "divided duty");
            check(cnt[1], 16'(6 * div_of(dv)), "dead time");
        end
        $display("test prescaler done");
        // independent mode, frozen reload, staged period
        wr(pwd_pkg::IDX_CFG, 8'h0d);
        set_ch(0, 8'h00, 12'h010, 12'h007, 12'h004);
        settle_measure(32);
        check(cnt[0], 16'h000e, "independent primary");
        check(cnt[1], 16'h0008, "independent secondary");
        wr(pwd_pkg::IDX_CFG, 8'h09);
        wr(ix(0, pwd_pkg::IDX_DUT_H), 8'h00);
        wr(ix(0, pwd_pkg::IDX_DUT_L), 8'h0a);
        settle_measure(32);
        check(cnt[0], 16'h000e, "frozen duty");
        wr(pwd_pkg::IDX_CFG, 8'h0d);
        settle_measure(32);
        check(cnt[0], 16'h0014, "reloaded duty");
        wr(ix(0, pwd_pkg::IDX_PER_H), 8'h01);
        settle_measure(32);
        check(cnt[0], 16'h0014, "period high alone");
        wr(ix(0, pwd_pkg::IDX_PER_L), 8'h10);
        settle_measure(544);
        check(cnt[0], 16'h0014, "combined period");
        $display("test independent done");
        // every output polarity code, random duty and dead time
        for (int p = 0; p < 4; p++) begin
            seed = lfsr_next(seed);
            d1 = 4 + seed[7:0] % 6;
            t1 = 1 + seed[15:8] % 3;
            set_ch(1, {4'h0, 2'(p), 2'b00}, 12'h018, 12'(d1), 12'(t1));
            settle_measure(48);
            check(cnt[2], exp_high(2 * d1, 48, p[1]), "primary polarity");
            check(cnt[3], exp_high(2 * (24 - d1 - 2 * t1), 48, p[0]), "secondary polarity");
        end
        $display("test polarity done");
        // overflow flag and interrupt gate
        wr(ix(1, pwd_pkg::IDX_CTRL), 8'h80);
        n = 0;
        while (ch1_irq !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        check(16'(ch1_irq), 16'h0001, "irq after overflow");
        wr(ix(1, pwd_pkg::IDX_CTRL), 8'h80);
        rd_check(ix(1, pwd_pkg::IDX_CTRL), 8'hff, 8'h80, "flag cleared");
        wr(ix(1, pwd_pkg::IDX_CTRL), 8'h00);
        repeat (30) @(posedge clk);
        check(16'(ch1_irq), 16'h0000, "irq gated off");
        check(16'(ch0_irq), 16'h0000, "ch0 irq never enabled");
        rd_check(ix(1, pwd_pkg::IDX_CTRL), 8'h40, 8'h40, "flag held");
        $display("test interrupt done");
        // fault shutdown for both trigger levels
        for (int f = 0; f < 2; f++) begin
            fault_level[1] <= ~f[0];
            wr(ix(1, pwd_pkg::IDX_CTRL), {3'b000, f[0], 4'h0});
            repeat (8) @(posedge clk);
            wr(ix(1, pwd_pkg::IDX_CTRL), {3'b000, f[0], 4'h0});
            rd_check(ix(1, pwd_pkg::IDX_CTRL), 8'h20, 8'h00, "no fault yet");
            fault_level[1] <= f[0];
            settle_measure(48);
            check(cnt[2] | cnt[3], 16'h0000, "outputs held off");
            rd_check(ix(1, pwd_pkg::IDX_CTRL), 8'h20, 8'h20, "fault status set");
            fault_level[1] <= ~f[0];
            repeat (8) @(posedge clk);
            wr(ix(1, pwd_pkg::IDX_CTRL), {3'b000, f[0], 4'h0});
            rd_check(ix(1, pwd_pkg::IDX_CTRL), 8'h20, 8'h00, "fault status cleared");
        end
        $display("test fault done");
        report_and_stop();
    end
endmodule
